/* File: src/aobgr_pkg.sv */
package aobgr_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] CTRL_BASE = 8'h00;
    localparam logic [7:0] STAT_BASE = 8'h10;
    localparam logic [7:0] CFG_OFF = 8'h20;
    localparam logic [7:0] SYS_STEP = 8'h04;
    localparam int NSYS_MAX = 4;

    // control word fields, one word per machining system
    localparam int C_BLK_HOLD = 0;
    localparam int C_CUT_HOLD = 1;
    localparam int C_DRY = 2;
    localparam int C_RAPID = 3;
    localparam int C_OVR = 4;
    localparam int C_INPOS = 5;
    localparam int C_KEEP = 6;
    localparam int C_INIT = 7;
    localparam int C_REWIND = 8;
    localparam int C_CHAMF = 9;
    localparam int C_JOG_LSB = 10;
    localparam int JOG_W = 5;
    localparam int CTRL_W = 15;
    // both interlocks come up released
    localparam logic [CTRL_W-1:0] CTRL_RST = 15'h0003;

    // status word fields
    localparam int S_RST = 0;
    localparam int S_RWD = 1;
    localparam int S_INH = 2;
    localparam int S_INPOS = 3;
    localparam int S_CHAMF = 4;
    localparam int S_STATE_LSB = 5;
    localparam int S_FEED_LSB = 7;
    localparam int STAT_W = 9;

    // config word
    localparam int G_DRY_RAPID = 0;
    localparam int CFG_W = 1;
    localparam logic [CFG_W-1:0] CFG_RST = 1'h0;

    // ************************************************************
    // states and encodings
    // ************************************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_INPOS = 2'b10,
        ST_DECEL = 2'b11
    } aobgr_state_t;

    typedef enum logic [1:0] {
        FD_PROG = 2'b00,
        FD_MAXCUT = 2'b01,
        FD_MANUAL = 2'b10,
        FD_RAPID = 2'b11
    } aobgr_feed_t;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_HZ = 20_000_000;
    localparam int RST_FLAG_MS = 500;
    localparam int RST_FLAG_CYC = CLK_HZ / 1000 * RST_FLAG_MS;
    localparam int DLY_W = 24;
endpackage

/* File: src/aobgr_dly.sv */
`timescale 1ns/1ps
module aobgr_dly #(
    parameter int W = aobgr_pkg::DLY_W,
    parameter logic [W-1:0] CYC = W'(aobgr_pkg::RST_FLAG_CYC)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic start,
    output logic busy,
    output logic done
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic next_done;

    // restart on every start pulse; done fires once when the count runs out
    always_comb begin
        next_cnt = cnt;
        next_done = 1'b0;
        if (start) begin
            next_cnt = CYC;
        end else if (cnt != '0) begin
            next_cnt = cnt - W'(1);
            next_done = (cnt == W'(1));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
            done <= 1'b0;
        end else if (ce) begin
            cnt <= next_cnt;
            done <= next_done;
        end
    end

    assign busy = (cnt != '0);
endmodule

/* File: src/aobgr_feed.sv */
`timescale 1ns/1ps
module aobgr_feed (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic dry_run_sel,
    input wire logic rapid_cmd,
    input wire logic manual_ovr_enable,
    input wire logic [aobgr_pkg::JOG_W-1:0] manual_feed_sel,
    input wire logic dry_rapid_en,
    input wire logic is_cut,
    input wire logic is_rapid,
    input wire logic manual_mode,
    output aobgr_pkg::aobgr_feed_t feed_src,
    output logic cut_ovr_en,
    output logic rapid_ovr_en,
    output logic [aobgr_pkg::JOG_W-1:0] manual_feed_code
);
    aobgr_pkg::aobgr_feed_t next_src;
    logic next_cut_ovr;
    logic next_rapid_ovr;

    // feed source; dry run never reaches manual jogging
    always_comb begin
        next_src = is_rapid ? aobgr_pkg::FD_RAPID : aobgr_pkg::FD_PROG;
        next_cut_ovr = is_cut;
        next_rapid_ovr = is_rapid;
        if (dry_run_sel && !manual_mode) begin
            if (is_cut) begin
                if (rapid_cmd) begin
                    next_src = aobgr_pkg::FD_MAXCUT;
                    next_cut_ovr = 1'b0;
                    next_rapid_ovr = 1'b0;
                end else begin
                    next_src = aobgr_pkg::FD_MANUAL;
                    next_cut_ovr = manual_ovr_enable;
                    next_rapid_ovr = 1'b0;
                end
            end else if (is_rapid && dry_rapid_en && !rapid_cmd) begin
                next_src = aobgr_pkg::FD_MANUAL;
                next_rapid_ovr = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            feed_src <= aobgr_pkg::FD_PROG;
            cut_ovr_en <= 1'b0;
            rapid_ovr_en <= 1'b0;
            manual_feed_code <= '0;
        end else if (ce) begin
            feed_src <= next_src;
            cut_ovr_en <= next_cut_ovr;
            rapid_ovr_en <= next_rapid_ovr;
            manual_feed_code <= manual_feed_sel;
        end
    end
endmodule

/* File: src/aobgr_top.sv */
// Contract
// - block start hold low: no next block
// - start hold covers internally generated blocks
// - both hold inputs come up high
// - cut hold low: only positioning blocks start
// - cut hold covers fixed cycle blocks
// - dry run, rapid high: max cutting feed
// - dry run, rapid low: manual feed, override
// - dry run on rapid needs enabling parameter
// - dry run off in manual, on tapping (no tapping input here; only manual mode turns dry run off)
// - inpos request pauses after cutting block
// - keep reset: index memory, stop, flag
// - init reset: modal init, cancel comp, flag
// - rewind reset: decelerate, reset, delayed flag
// - rewind reset raises rewinding, memory rewinds
// - rewind request high blocks all operation
// - rewind reset: init, cancel, clear strobes
// - chamfer at thread end may be suppressed
// - chamfer input sampled at thread start
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module aobgr_top #(
    parameter int NSYS = 3,
    parameter int RST_DLY_CYC = aobgr_pkg::RST_FLAG_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NSYS-1:0] blk_req,
    input wire logic [NSYS-1:0] blk_motion,
    input wire logic [NSYS-1:0] blk_cut,
    input wire logic [NSYS-1:0] blk_rapid,
    input wire logic [NSYS-1:0] blk_thread,
    input wire logic [NSYS-1:0] blk_done,
    input wire logic [NSYS-1:0] inpos_ok,
    input wire logic [NSYS-1:0] axis_stopped,
    input wire logic [NSYS-1:0] auto_mode,
    input wire logic [NSYS-1:0] mem_mode,
    input wire logic [NSYS-1:0] manual_mode,
    output logic [NSYS-1:0] blk_start,
    output logic [NSYS-1:0] inpos_wait,
    output logic [NSYS-1:0] chamfer_en,
    output logic [NSYS-1:0] decel_stop,
    output logic [NSYS-1:0] motion_stop,
    output logic [NSYS-1:0] modal_init,
    output logic [NSYS-1:0] comp_cancel,
    output logic [NSYS-1:0] mem_index,
    output logic [NSYS-1:0] alarm_clr,
    output logic [NSYS-1:0] strobe_clr,
    output logic [NSYS-1:0] mout_clr,
    output logic [NSYS-1:0] in_reset_flag,
    output logic [NSYS-1:0] rewinding_flag,
    output logic [NSYS-1:0] op_inhibit,
    output logic [2*NSYS-1:0] feed_src,
    output logic [NSYS-1:0] cut_ovr_en,
    output logic [NSYS-1:0] rapid_ovr_en,
    output logic [aobgr_pkg::JOG_W*NSYS-1:0] manual_feed_code
);
    localparam int JW = aobgr_pkg::JOG_W;
    localparam logic [aobgr_pkg::DLY_W-1:0] DLY_CYC = aobgr_pkg::DLY_W'(RST_DLY_CYC);

    // ************************************************************
    // register file and apb slave
    // ************************************************************
    logic [aobgr_pkg::CTRL_W-1:0] ctrl [NSYS];
    logic [aobgr_pkg::CTRL_W-1:0] next_ctrl [NSYS];
    logic [aobgr_pkg::CFG_W-1:0] cfg;
    logic [aobgr_pkg::CFG_W-1:0] next_cfg;
    logic [31:0] next_prdata;
    logic [aobgr_pkg::STAT_W-1:0] stat [NSYS];
    logic hit;
    logic wr_en;

    // zero wait states; decode is purely combinational
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign wr_en = psel & penable & pwrite & hit;

    // address decode, write update and read data capture
    always_comb begin
        hit = (paddr == aobgr_pkg::CFG_OFF);
        next_cfg = cfg;
        next_prdata = prdata;
        if (psel && !penable) begin
            next_prdata = '0;
        end
        if (wr_en && paddr == aobgr_pkg::CFG_OFF) begin
            next_cfg = pwdata[aobgr_pkg::CFG_W-1:0];
        end
        if (psel && !penable && !pwrite && paddr == aobgr_pkg::CFG_OFF) begin
            next_prdata = 32'(cfg);
        end
        for (int i = 0; i < NSYS; i++) begin
            next_ctrl[i] = ctrl[i];
            if (paddr == aobgr_pkg::CTRL_BASE + 8'(i) * aobgr_pkg::SYS_STEP) begin
                hit = 1'b1;
                if (wr_en) begin
                    next_ctrl[i] = pwdata[aobgr_pkg::CTRL_W-1:0];
                end
                if (psel && !penable && !pwrite) begin
                    next_prdata = 32'(ctrl[i]);
                end
            end
            if (paddr == aobgr_pkg::STAT_BASE + 8'(i) * aobgr_pkg::SYS_STEP) begin
                hit = 1'b1; // status words ignore writes
                if (psel && !penable && !pwrite) begin
                    next_prdata = 32'(stat[i]);
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NSYS; i++) begin
                ctrl[i] <= aobgr_pkg::CTRL_RST;
            end
            cfg <= aobgr_pkg::CFG_RST;
            prdata <= '0;
        end else if (ce) begin
            for (int i = 0; i < NSYS; i++) begin
                ctrl[i] <= next_ctrl[i];
            end
            cfg <= next_cfg;
            prdata <= next_prdata;
        end
    end

    // ************************************************************
    // control field views, one bit per system
    // ************************************************************
    logic [NSYS-1:0] hold_n_v;
    logic [NSYS-1:0] cut_hold_n_v;
    logic [NSYS-1:0] inpos_req_v;
    logic [NSYS-1:0] keep_v;
    logic [NSYS-1:0] init_v;
    logic [NSYS-1:0] rrw_v;
    logic [NSYS-1:0] chamf_n_v;

    // every system reads only its own control word
    always_comb begin
        for (int i = 0; i < NSYS; i++) begin
            hold_n_v[i] = ctrl[i][aobgr_pkg::C_BLK_HOLD];
            cut_hold_n_v[i] = ctrl[i][aobgr_pkg::C_CUT_HOLD];
            inpos_req_v[i] = ctrl[i][aobgr_pkg::C_INPOS];
            keep_v[i] = ctrl[i][aobgr_pkg::C_KEEP];
            init_v[i] = ctrl[i][aobgr_pkg::C_INIT];
            rrw_v[i] = ctrl[i][aobgr_pkg::C_REWIND];
            chamf_n_v[i] = ctrl[i][aobgr_pkg::C_CHAMF];
        end
    end

    // ************************************************************
    // block gating and reset sequencing
    // ************************************************************
    aobgr_pkg::aobgr_state_t state [NSYS];
    aobgr_pkg::aobgr_state_t next_state [NSYS];
    logic [NSYS-1:0] cut_lat, next_cut_lat;
    logic [NSYS-1:0] next_chamf, next_rst, next_rwd;
    logic [NSYS-1:0] keep_q, init_q, rrw_q;
    logic [NSYS-1:0] tmr_start, next_tmr_start;
    logic [NSYS-1:0] tmr_busy, tmr_done;
    logic [NSYS-1:0] next_blk_start, next_motion_stop, next_modal_init;
    logic [NSYS-1:0] next_comp_cancel, next_mem_index, next_alarm_clr;
    logic [NSYS-1:0] next_strobe_clr, next_mout_clr;

    // one sequencer per system; rewind request beats the soft resets
    always_comb begin
        for (int i = 0; i < NSYS; i++) begin
            next_state[i] = state[i];
            next_cut_lat[i] = cut_lat[i];
            next_chamf[i] = chamfer_en[i];
            next_rst[i] = in_reset_flag[i];
            next_rwd[i] = rewinding_flag[i];
            next_tmr_start[i] = 1'b0;
            next_blk_start[i] = 1'b0;
            next_motion_stop[i] = 1'b0;
            next_modal_init[i] = 1'b0;
            next_comp_cancel[i] = 1'b0;
            next_mem_index[i] = 1'b0;
            next_alarm_clr[i] = 1'b0;
            next_strobe_clr[i] = 1'b0;
            next_mout_clr[i] = 1'b0;
            case (state[i])
                aobgr_pkg::ST_IDLE: begin
                    // interlocks looked at only at the boundary, any block source
                    if (blk_req[i] && auto_mode[i] && !rrw_v[i] && hold_n_v[i]
                        && (cut_hold_n_v[i] || !blk_motion[i])) begin
                        next_blk_start[i] = 1'b1;
                        next_state[i] = aobgr_pkg::ST_RUN;
                        next_cut_lat[i] = blk_cut[i];
                        if (blk_thread[i]) begin
                            next_chamf[i] = ~chamf_n_v[i];
                        end
                    end
                end
                aobgr_pkg::ST_RUN: begin
                    // a running block finishes whatever the interlocks do, unless a keep, init or rewind request cuts it short
                    if (blk_done[i]) begin
                        if (cut_lat[i] && inpos_req_v[i]) begin
                            next_state[i] = aobgr_pkg::ST_INPOS;
                        end else begin
                            next_state[i] = aobgr_pkg::ST_IDLE;
                        end
                    end
                end
                aobgr_pkg::ST_INPOS: begin
                    if (inpos_ok[i]) begin
                        next_state[i] = aobgr_pkg::ST_IDLE;
                    end
                end
                aobgr_pkg::ST_DECEL: begin
                    // reset happens only once the axes have come to rest
                    if (axis_stopped[i]) begin
                        next_state[i] = aobgr_pkg::ST_IDLE;
                        next_modal_init[i] = 1'b1;
                        next_comp_cancel[i] = 1'b1;
                        next_alarm_clr[i] = 1'b1;
                        next_strobe_clr[i] = 1'b1;
                        next_mout_clr[i] = 1'b1;
                        next_mem_index[i] = mem_mode[i];
                        next_rwd[i] = 1'b1;
                        next_tmr_start[i] = 1'b1;
                    end
                end
                default: begin
                    next_state[i] = aobgr_pkg::ST_IDLE;
                end
            endcase
            // flags drop once no request stands and no delay runs
            if (!keep_v[i] && !init_v[i] && !rrw_v[i] && !tmr_busy[i] && !tmr_start[i]
                && state[i] != aobgr_pkg::ST_DECEL) begin
                next_rst[i] = 1'b0;
                next_rwd[i] = 1'b0;
            end
            if (keep_v[i] && !keep_q[i]) begin
                next_state[i] = aobgr_pkg::ST_IDLE;
                next_mem_index[i] = 1'b1;
                next_alarm_clr[i] = 1'b1;
                next_mout_clr[i] = 1'b1;
                next_motion_stop[i] = 1'b1;
                next_rst[i] = 1'b1;
            end
            if (init_v[i] && !init_q[i]) begin
                next_state[i] = aobgr_pkg::ST_IDLE;
                next_modal_init[i] = 1'b1;
                next_comp_cancel[i] = 1'b1;
                next_alarm_clr[i] = 1'b1;
                next_mout_clr[i] = 1'b1;
                next_motion_stop[i] = 1'b1;
                next_rst[i] = 1'b1;
            end
            if (rrw_v[i] && !rrw_q[i]) begin
                next_state[i] = aobgr_pkg::ST_DECEL;
            end
            if (tmr_done[i]) begin
                next_rst[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NSYS; i++) begin
                state[i] <= aobgr_pkg::ST_IDLE;
            end
            cut_lat <= '0;
            chamfer_en <= '0;
            in_reset_flag <= '0;
            rewinding_flag <= '0;
            keep_q <= '0;
            init_q <= '0;
            rrw_q <= '0;
            tmr_start <= '0;
            blk_start <= '0;
            motion_stop <= '0;
            modal_init <= '0;
            comp_cancel <= '0;
            mem_index <= '0;
            alarm_clr <= '0;
            strobe_clr <= '0;
            mout_clr <= '0;
        end else if (ce) begin
            for (int i = 0; i < NSYS; i++) begin
                state[i] <= next_state[i];
            end
            cut_lat <= next_cut_lat;
            chamfer_en <= next_chamf;
            in_reset_flag <= next_rst;
            rewinding_flag <= next_rwd;
            keep_q <= keep_v;
            init_q <= init_v;
            rrw_q <= rrw_v;
            tmr_start <= next_tmr_start;
            blk_start <= next_blk_start;
            motion_stop <= next_motion_stop;
            modal_init <= next_modal_init;
            comp_cancel <= next_comp_cancel;
            mem_index <= next_mem_index;
            alarm_clr <= next_alarm_clr;
            strobe_clr <= next_strobe_clr;
            mout_clr <= next_mout_clr;
        end
    end

    // decodes of registered state; inhibit follows the registered request
    always_comb begin
        for (int i = 0; i < NSYS; i++) begin
            inpos_wait[i] = (state[i] == aobgr_pkg::ST_INPOS);
            decel_stop[i] = (state[i] == aobgr_pkg::ST_DECEL);
            op_inhibit[i] = rrw_q[i];
            stat[i] = {feed_src[2*i +: 2], 2'(state[i]), chamfer_en[i], inpos_wait[i],
                op_inhibit[i], rewinding_flag[i], in_reset_flag[i]};
        end
    end

    // ************************************************************
    // per-system feed selection and reset flag delay
    // ************************************************************
    for (genvar g = 0; g < NSYS; g++) begin : g_sys
        aobgr_pkg::aobgr_feed_t src;

        aobgr_feed u_feed (
            .pclk(pclk),
            .presetn(presetn),
            .ce(ce),
            .dry_run_sel(ctrl[g][aobgr_pkg::C_DRY]),
            .rapid_cmd(ctrl[g][aobgr_pkg::C_RAPID]),
            .manual_ovr_enable(ctrl[g][aobgr_pkg::C_OVR]),
            .manual_feed_sel(ctrl[g][aobgr_pkg::C_JOG_LSB +: JW]),
            .dry_rapid_en(cfg[aobgr_pkg::G_DRY_RAPID]),
            .is_cut(blk_cut[g]),
            .is_rapid(blk_rapid[g]),
            .manual_mode(manual_mode[g]),
            .feed_src(src),
            .cut_ovr_en(cut_ovr_en[g]),
            .rapid_ovr_en(rapid_ovr_en[g]),
            .manual_feed_code(manual_feed_code[g*JW +: JW])
        );
        assign feed_src[2*g +: 2] = 2'(src);

        // long wait is a parameter so simulation can shorten it
        aobgr_dly #(
            .W(aobgr_pkg::DLY_W),
            .CYC(DLY_CYC)
        ) u_dly (
            .pclk(pclk),
            .presetn(presetn),
            .ce(ce),
            .start(tmr_start[g]),
            .busy(tmr_busy[g]),
            .done(tmr_done[g])
        );
    end
endmodule

/* File: tb/aobgr_props.sv */
`timescale 1ns/1ps
module aobgr_props #(
    parameter int NSYS = 3,
    parameter int RST_DLY_CYC = 20
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [NSYS-1:0] blk_req,
    input wire logic [NSYS-1:0] auto_mode,
    input wire logic [NSYS-1:0] blk_start,
    input wire logic [NSYS-1:0] blk_done,
    input wire logic [NSYS-1:0] inpos_wait,
    input wire logic [NSYS-1:0] inpos_ok,
    input wire logic [NSYS-1:0] decel_stop,
    input wire logic [NSYS-1:0] rewinding_flag,
    input wire logic [NSYS-1:0] modal_init,
    input wire logic [NSYS-1:0] comp_cancel,
    input wire logic [NSYS-1:0] mem_index,
    input wire logic [NSYS-1:0] in_reset_flag,
    input wire logic [2*NSYS-1:0] feed_src,
    input wire logic [NSYS-1:0] cut_ovr_en
);
    // ****************************************
    // system 0 watched; other copies identical
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_start_cause: assert property (blk_start[0] |-> $past(blk_req[0] && auto_mode[0]))
        else $error("block start without pending block");
    a_start_pulse: assert property (blk_start[0] |=> !blk_start[0])
        else $error("block start longer than one cycle");
    a_no_start_rwd: assert property (decel_stop[0] |-> !blk_start[0])
        else $error("block start during rewind");
    a_inpos_cause: assert property ($rose(inpos_wait[0]) |-> $past(blk_done[0]))
        else $error("inpos pause without block end");
    a_inpos_end: assert property (inpos_wait[0] && inpos_ok[0] && ce |=> !inpos_wait[0])
        else $error("inpos pause kept after inpos reached");
    a_rwd_pulse: assert property ($rose(rewinding_flag[0]) |-> modal_init[0] && comp_cancel[0])
        else $error("rewind without modal init");
    a_index_flag: assert property (mem_index[0] |-> in_reset_flag[0] || rewinding_flag[0])
        else $error("memory index without reset flag");
    a_maxcut_ovr: assert property (feed_src[1:0] == 2'b01 |-> !cut_ovr_en[0])
        else $error("override active at max cut feed");
    c_start: cover property (blk_start[0]);
    c_inpos: cover property ($rose(inpos_wait[0]));
    c_rewind: cover property ($rose(rewinding_flag[0]));
endmodule

/* File: tb/aobgr_plc.sv */
`timescale 1ns/1ps
module aobgr_plc #(
    parameter int NSYS = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire logic [NSYS-1:0] blk_start,
    input wire logic [NSYS-1:0] inpos_wait,
    input wire logic [NSYS-1:0] decel_stop,
    output logic [NSYS-1:0] blk_done,
    output logic [NSYS-1:0] inpos_ok,
    output logic [NSYS-1:0] axis_stopped
);
    // ****************************************
    // machine side: blocks, servo, axes
    // ****************************************
    logic [NSYS-1:0] d1, d2, d3, d4, i1, i2, s1, s2;
    // delay lines; slow mode stretches each block to four cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {d1, d2, d3, d4, i1, i2, s1, s2} <= '0;
        end else begin
            {d1, d2, d3, d4} <= {blk_start, d1, d2, d3};
            {i1, i2, s1, s2} <= {inpos_wait, i1, decel_stop, s1};
        end
    end
    assign blk_done = slow ? d4 : d1;
    assign inpos_ok = i2;
    assign axis_stopped = s2;
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, pready, pslverr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [2:0] blk_req = 0, blk_motion = 0, blk_cut = 0, blk_rapid = 0, auto_mode = 0, mem_mode = 0;
    logic [2:0] manual_mode = 0, blk_done, inpos_ok, axis_stopped, blk_start, inpos_wait, decel_stop;
    logic [2:0] mem_index, modal_init;
    logic [4:0] jog;
    logic [7:0] t;
    logic [64:0] ent;
    logic [64:0] q[$];
    int n_fail = 0, checked = 0, starts = 0, inposes = 0, idx = 0, mis = 0;
    logic [7:0] tbl [6] = '{8'h19, 8'h12, 8'h53, 8'hd2, 8'hdb, 8'h30};
    aobgr_top #(.NSYS(3), .RST_DLY_CYC(20)) i_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .blk_req(blk_req), .blk_motion(blk_motion), .blk_cut(blk_cut),
        .blk_rapid(blk_rapid), .blk_thread(blk_cut), .blk_done(blk_done), .inpos_ok(inpos_ok),
        .axis_stopped(axis_stopped), .auto_mode(auto_mode), .mem_mode(mem_mode), .manual_mode(manual_mode),
        .blk_start(blk_start), .inpos_wait(inpos_wait), .chamfer_en(), .decel_stop(decel_stop),
        .motion_stop(), .modal_init(modal_init), .comp_cancel(), .mem_index(mem_index), .alarm_clr(),
        .strobe_clr(), .mout_clr(), .in_reset_flag(), .rewinding_flag(), .op_inhibit(), .feed_src(),
        .cut_ovr_en(), .rapid_ovr_en(), .manual_feed_code());
    aobgr_plc #(.NSYS(3)) i_plc (.*);
    always #25 pclk = ~pclk;
    // ****************************************
    // monitor: pulse counts and read results
    // ****************************************
    always @(posedge pclk) begin
        starts += blk_start[0];
        inposes += inpos_wait[0];
        idx += mem_index[0];
        mis += modal_init[0];
        if (psel && penable && pready && !pwrite) begin
            ent = q.pop_front();
            `CHK("prdata", ent[31:0], prdata & ent[63:32])
            `CHK("pslverr", ent[64], pslverr)
        end
    end
    task automatic close_out();
        if (n_fail == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // one transfer; a read notes {error, mask, data} first
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                       input logic e);
        int i;
        if (!w) q.push_back({e, m, d});
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready) break;
        end
        if (i == 16) begin
            n_fail++;
            close_out();
        end
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    initial begin
        void'($urandom(49));
        repeat (12) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, 8'h00, 32'h3, 32'hffffffff, 0);
        apb(0, 8'h30, 32'h0, 32'hffffffff, 1);
        jog = 5'($urandom);
        apb(1, 8'h00, {17'h0, jog, 10'h003}, 0, 0);
        apb(0, 8'h00, {17'h0, jog, 10'h003}, 32'hffffffff, 0);
        apb(1, 8'h00, 32'h2, 0, 0);
        {auto_mode, blk_req, blk_motion} <= 9'o111;
        wt(20);
        `CHK("held start", 0, starts)
        apb(1, 8'h00, 32'h1, 0, 0);
        wt(20);
        `CHK("cut hold start", 0, starts)
        blk_motion <= 0;
        wt(20);
        `CHK("position start", 1'b1, starts > 0)
        {blk_cut, blk_motion, slow} <= 7'b0010011;
        // cut blocks double as thread blocks; chamfer inhibited here
        apb(1, 8'h00, 32'h223, 0, 0);
        wt(30);
        `CHK("inpos pause", 1'b1, inposes > 0)
        apb(0, 8'h10, 32'h0, 32'h10, 0);
        blk_req <= 0;
        wt(10);
        // dry run feed selection table: {cfg, rapid blk, manual, dry, rapid cmd, -, feed}
        foreach (tbl[k]) begin
            t = tbl[k];
            apb(1, 8'h20, {31'h0, t[7]}, 0, 0);
            {blk_rapid, blk_cut, manual_mode} <= {2'b0, t[6], 2'b0, !t[6], 2'b0, t[5]};
            apb(1, 8'h00, {28'h0, t[3], t[4], 2'b11}, 0, 0);
            wt(3);
            apb(0, 8'h10, {23'h0, t[1:0], 7'h0}, 32'h180, 0);
        end
        manual_mode <= 0;
        {idx, mis} = 0;
        apb(1, 8'h00, 32'h43, 0, 0);
        wt(5);
        apb(0, 8'h10, 32'h1, 32'h1, 0);
        `CHK("keep index", 2'b10, {idx > 0, mis > 0})
        apb(1, 8'h00, 32'h3, 0, 0);
        {idx, mis} = 0;
        apb(1, 8'h00, 32'h83, 0, 0);
        wt(5);
        `CHK("init modal", 2'b01, {idx > 0, mis > 0})
        apb(1, 8'h00, 32'h3, 0, 0);
        {mem_mode, blk_req} <= 6'o11;
        idx = 0;
        // program end answered by rewind request only, never by a done acknowledge
        apb(1, 8'h00, 32'h103, 0, 0);
        wt(40);
        starts = 0;
        wt(10);
        `CHK("rewind start", 0, starts)
        apb(0, 8'h10, 32'h17, 32'h17, 0);
        `CHK("rewind index", 1'b1, idx > 0)
        apb(1, 8'h00, 32'h3, 0, 0);
        blk_req <= 0;
        wt(10);
        apb(0, 8'h10, 32'h0, 32'h3, 0);
        close_out();
    end
endmodule
bind aobgr_top aobgr_props #(.NSYS(NSYS), .RST_DLY_CYC(RST_DLY_CYC)) i_props (.*);
